// [common/eew_pkg.sv]
package eew_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int STANDBY_DELAY_NS = 200;
    localparam int STANDBY_DELAY_CYC = (STANDBY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_TYP_US = 5000;
    localparam int WRITE_MAX_US = 10000;
    localparam int WRITE_TYP_CYC = (WRITE_TYP_US * 1000) / CLK_PERIOD_NS;
    localparam int WRITE_MAX_CYC = (WRITE_MAX_US * 1000) / CLK_PERIOD_NS;
    // ----------------------------------------
    // Serial byte layout
    // ----------------------------------------
    localparam int ADDR_W = 7;
    localparam int RW_BIT = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [6:0] DEV_ADDR_RST = 7'h2A; // Arbitrary select value
    // ----------------------------------------
    // Power and bus states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ADDR,
        ST_WRITE,
        ST_READ,
        ST_LINGER,
        ST_PROGRAM
    } eew_state_t;
endpackage : eew_pkg

// [common/eew_timer_if.sv]
`timescale 1ns/1ps
interface eew_timer_if;
    logic launch;
    logic busy;
    logic done;
    modport ctrl (output launch, input busy, input done);
    modport timer (input launch, output busy, output done);
endinterface : eew_timer_if

// [hw/eew_write_timer.sv]
`timescale 1ns/1ps
module eew_write_timer #(
    parameter int WRITE_CYCLES = eew_pkg::WRITE_TYP_CYC,
    parameter int CNT_W = 22
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    eew_timer_if.timer wt
);
    import eew_pkg::*;

    if (WRITE_CYCLES < 1 || WRITE_CYCLES > WRITE_MAX_CYC ||
            WRITE_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
        $error("eew_write_timer: WRITE_CYCLES out of range");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] elapsed_reg;
    logic busy_reg;
    logic done_reg;

    // ----------------------------------------
    // Self-timed write countdown
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            done_reg <= 1'b0;
            if (wt.launch && !busy_reg) begin
                busy_reg <= 1'b1;
                cnt_reg <= CNT_W'(WRITE_CYCLES - 1);
            end else if (busy_reg) begin
                if (cnt_reg == '0) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end

    assign wt.busy = busy_reg;
    assign wt.done = done_reg;

    // Checking aid only
    always_ff @(posedge core_clk) begin
        if (sys_rst || !busy_reg) begin
            elapsed_reg <= '0;
        end else begin
            elapsed_reg <= elapsed_reg + 1'b1;
        end
    end

    property p_write_bound;
        @(posedge core_clk) disable iff (sys_rst)
        busy_reg |-> (elapsed_reg < CNT_W'(WRITE_MAX_CYC));
    endproperty
    a_write_bound: assert property (p_write_bound)
        else $error("internal write exceeds its longest time");

    property p_launch_busy;
        @(posedge core_clk) disable iff (sys_rst)
        (wt.launch && !busy_reg) |=> busy_reg && !done_reg;
    endproperty
    a_launch_busy: assert property (p_launch_busy)
        else $error("launch did not start the write timer");
endmodule : eew_write_timer

// [hw/eew_core.sv]
`timescale 1ns/1ps
// Behaviour
// - Any start condition wakes the device from standby into active.
// - Address mismatch returns to standby at the ninth clock after start.
// - A stop that launches no write gives standby 200 ns later.
// - Stop ending a write launches it; stay active until it finishes.
// - Internal write completes within 10 ms of its stop, typically 5 ms.
// - During the internal write the bus is ignored and address not acknowledged.
// - During the internal write the data line is never pulled low.
module eew_core #(
    parameter logic [eew_pkg::ADDR_W-1:0] DEV_ADDR = eew_pkg::DEV_ADDR_RST,
    parameter int WRITE_CYCLES = eew_pkg::WRITE_TYP_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] rd_data,
    output logic rd_req,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic active,
    output logic write_busy
);
    import eew_pkg::*;

    if (STANDBY_DELAY_CYC < 2 || STANDBY_DELAY_CYC > 257) begin : g_bad_delay
        $error("eew_core: standby delay does not fit the linger counter");
    end

    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;
    logic scl_rise, scl_fall, start_det, stop_det, nine_rise, addr_hit;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg, tx_reg, linger_reg, wr_data_reg;
    logic nack_reg, wrote_reg, launch_reg;
    logic sda_oe_reg, sda_out_reg, rd_req_reg, wr_strobe_reg, active_reg, busy_reg;
    eew_state_t state_reg;
    eew_timer_if wt ();

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {scl_d_reg, scl_s_reg, scl_m_reg} <= 3'h7;
            {sda_d_reg, sda_s_reg, sda_m_reg} <= 3'h7;
        end else begin
            {scl_d_reg, scl_s_reg, scl_m_reg} <= {scl_s_reg, scl_m_reg, scl_in};
            {sda_d_reg, sda_s_reg, sda_m_reg} <= {sda_s_reg, sda_m_reg, sda_in};
        end
    end

    assign scl_rise = scl_s_reg && !scl_d_reg;
    assign scl_fall = !scl_s_reg && scl_d_reg;
    assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
    assign stop_det = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
    assign nine_rise = scl_rise && (bit_cnt_reg == BITS_PER_BYTE);
    assign addr_hit = (shift_reg[7:1] == DEV_ADDR);

    // ----------------------------------------
    // Bit counter and receive shifter
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst || start_det || stop_det) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_fall && bit_cnt_reg == ACK_SLOT) begin
            bit_cnt_reg <= 4'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg <= 8'h00;
        end else if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_s_reg};
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_STANDBY;
        end else begin
            unique case (state_reg)
                ST_STANDBY: begin
                    if (start_det)
                        state_reg <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (stop_det)
                        state_reg <= ST_LINGER;
                    else if (nine_rise && !addr_hit)
                        state_reg <= ST_STANDBY;
                    else if (nine_rise)
                        state_reg <= shift_reg[RW_BIT] ? ST_READ : ST_WRITE;
                end
                ST_WRITE: begin
                    if (stop_det)
                        state_reg <= wrote_reg ? ST_PROGRAM : ST_LINGER;
                    else if (start_det)
                        state_reg <= ST_ADDR;
                end
                ST_READ: begin
                    if (stop_det)
                        state_reg <= ST_LINGER;
                    else if (start_det)
                        state_reg <= ST_ADDR;
                end
                ST_LINGER: begin
                    if (start_det)
                        state_reg <= ST_ADDR;
                    else if (linger_reg == 8'h00)
                        state_reg <= ST_STANDBY;
                end
                ST_PROGRAM: begin
                    // Starts are ignored here; polling masters see no acknowledge
                    if (wt.done)
                        state_reg <= ST_STANDBY;
                end
                default: state_reg <= ST_STANDBY;
            endcase
        end
    end

    // Load so that standby arrives exactly the delay after the stop
    always_ff @(posedge core_clk) begin
        if (sys_rst || state_reg != ST_LINGER) begin
            linger_reg <= 8'(STANDBY_DELAY_CYC - 2);
        end else if (linger_reg != 8'h00) begin
            linger_reg <= linger_reg - 8'h01;
        end
    end

    // ----------------------------------------
    // Write sequence and launch
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrote_reg <= 1'b0;
            launch_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            wr_strobe_reg <= 1'b0;
        end else begin
            launch_reg <= (state_reg == ST_WRITE) && stop_det && wrote_reg;
            wr_strobe_reg <= 1'b0;
            if (state_reg == ST_WRITE && nine_rise) begin
                wr_data_reg <= shift_reg;
                wr_strobe_reg <= 1'b1;
                wrote_reg <= 1'b1;
            end else if (start_det || stop_det) begin
                wrote_reg <= 1'b0;
            end
        end
    end

    assign wt.launch = launch_reg;

    eew_write_timer #(
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wt(wt)
    );

    // ----------------------------------------
    // Data line drive: acknowledge and read bits
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst || start_det) begin
            nack_reg <= 1'b0;
        end else if (state_reg == ST_READ && nine_rise) begin
            nack_reg <= sda_s_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_oe_reg <= 1'b0;
            tx_reg <= 8'h00;
            rd_req_reg <= 1'b0;
        end else begin
            rd_req_reg <= 1'b0;
            if (state_reg == ST_PROGRAM || start_det || stop_det) begin
                sda_oe_reg <= 1'b0;
            end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                sda_oe_reg <= (state_reg == ST_ADDR && addr_hit) || state_reg == ST_WRITE;
            end else if (scl_fall && bit_cnt_reg == ACK_SLOT) begin
                sda_oe_reg <= (state_reg == ST_READ) && !nack_reg && !rd_data[7];
                if (state_reg == ST_READ && !nack_reg) begin
                    tx_reg <= {rd_data[6:0], 1'b1};
                    rd_req_reg <= 1'b1;
                end
            end else if (scl_fall && state_reg == ST_READ && !nack_reg) begin
                sda_oe_reg <= !tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b1};
            end else if (scl_fall) begin
                sda_oe_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Status lags the state by one cycle to keep outputs on flops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_out_reg <= 1'b0;
            active_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            sda_out_reg <= 1'b0;
            active_reg <= (state_reg != ST_STANDBY);
            busy_reg <= (state_reg == ST_PROGRAM);
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign rd_req = rd_req_reg;
    assign wr_data = wr_data_reg;
    assign wr_strobe = wr_strobe_reg;
    assign active = active_reg;
    assign write_busy = busy_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_write_stop;
        (state_reg == ST_WRITE) && stop_det && wrote_reg;
    endsequence

    sequence s_programming;
        ##1 (state_reg == ST_PROGRAM) && launch_reg;
    endsequence

    property p_wake;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_STANDBY && start_det) |=> (state_reg == ST_ADDR) ##1 active_reg;
    endproperty
    a_wake: assert property (p_wake)
        else $error("start did not wake the device");

    property p_mismatch;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_ADDR && nine_rise && !addr_hit && !stop_det) |=>
            (state_reg == ST_STANDBY) && !sda_oe_reg;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatched address did not return to standby");

    property p_linger_load;
        @(posedge core_clk) disable iff (sys_rst)
        (stop_det && state_reg == ST_READ) |=> (state_reg == ST_LINGER) &&
            (linger_reg == 8'(STANDBY_DELAY_CYC - 2));
    endproperty
    a_linger_load: assert property (p_linger_load)
        else $error("read stop did not start the standby delay");

    property p_linger_end;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_LINGER && linger_reg == 8'h00 && !start_det) |=>
            (state_reg == ST_STANDBY) ##1 !active_reg;
    endproperty
    a_linger_end: assert property (p_linger_end)
        else $error("standby delay did not end in standby");

    property p_launch;
        @(posedge core_clk) disable iff (sys_rst)
        s_write_stop |-> s_programming ##1 wt.busy;
    endproperty
    a_launch: assert property (p_launch)
        else $error("write stop did not launch the internal write");

    property p_stay_active;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_PROGRAM && !wt.done) |=> (state_reg == ST_PROGRAM);
    endproperty
    a_stay_active: assert property (p_stay_active)
        else $error("left the write state before completion");

    property p_no_drive;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_PROGRAM) |=> !sda_oe_reg;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("data line pulled low during internal write");
endmodule : eew_core

// [tb/eew_master_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module eew_master_model (
    input wire logic core_clk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_level
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic start_cond;
        @(posedge core_clk);
        #1;
        sda_drv = 1'b1;
        // Release data before raising the clock so a repeated start works too
        #20 scl = 1'b1;
        #20 sda_drv = 1'b0;
        #40 scl = 1'b0;
    endtask : start_cond

    // Data changes mid-low, sampled mid-high
    task automatic bit_xfer(input logic b, output logic s);
        #20 sda_drv = b;
        #20 scl = 1'b1;
        #20 s = sda_level;
        #20 scl = 1'b0;
    endtask : bit_xfer

    task automatic byte_xfer(input logic [7:0] tx, input logic ack_tx,
                             output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(tx[i], rx[i]);
        end
        bit_xfer(ack_tx, ack_rx);
    endtask : byte_xfer

    task automatic stop_cond;
        #20 sda_drv = 1'b0;
        #20 scl = 1'b1;
        #20 sda_drv = 1'b1;
    endtask : stop_cond

    // Polling ends early instead of sitting out the longest write time
    task automatic poll_ack(input logic [7:0] addr, input int max_tries, output int tries);
        logic [7:0] rx;
        logic ack;
        tries = 0;
        ack = 1'b1;
        while (ack !== 1'b0 && tries < max_tries) begin
            start_cond();
            byte_xfer(addr, 1'b1, rx, ack);
            stop_cond();
            tries++;
        end
    endtask : poll_ack
endmodule : eew_master_model

// [tb/tb_eew_core.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Bench for power state and write cycle
// ----------------------------------------
module tb_eew_core;
    import eew_pkg::*;
    localparam logic [6:0] DEV = 7'h35;
    localparam int WC = 400;
    localparam int PU_WRITE_CYC = 50;
    localparam logic [7:0] RD_BYTE = 8'h96;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl;
    logic sda_drv;
    logic sda_level;
    logic sda_out, sda_oe, rd_req, wr_strobe, active, write_busy;
    logic [7:0] wr_data;
    logic [7:0] last_wr = 8'h00;
    int busy_cyc = 0;
    int oe_busy = 0;
    int busy_idle = 0;
    int rd_pulses = 0;
    int miscompares = 0;
    int n_compared = 0;

    always #2 core_clk = ~core_clk;
    // Pull-up wire: low if either side pulls
    assign sda_level = sda_drv & ~(sda_oe & ~sda_out);

    always @(posedge core_clk) begin
        if (wr_strobe === 1'b1) last_wr <= wr_data;
        if (rd_req === 1'b1) rd_pulses <= rd_pulses + 1;
        if (write_busy === 1'b1) busy_cyc <= busy_cyc + 1;
        if (write_busy === 1'b1 && sda_oe !== 1'b0) oe_busy <= oe_busy + 1;
        if (write_busy === 1'b1 && active !== 1'b1) busy_idle <= busy_idle + 1;
    end

    eew_core #(.DEV_ADDR(DEV), .WRITE_CYCLES(WC)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_level),
        .sda_out(sda_out), .sda_oe(sda_oe), .rd_data(RD_BYTE), .rd_req(rd_req),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .active(active), .write_busy(write_busy)
    );
    eew_master_model i_master (
        .core_clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda_level(sda_level)
    );

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("Checks: %0d compared, %0d miscompared", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check_val

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_range

    task automatic wait_active(input logic lvl, input int bound, output int n);
        n = 0;
        while (active !== lvl) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > bound) begin
                miscompares++;
                $display("ERROR active expected %0b seen timeout", lvl);
                tally_and_finish();
            end
        end
    endtask : wait_active

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_mismatch;
        logic [7:0] a;
        logic s;
        a = {DEV ^ 7'h01, 1'b0};
        i_master.start_cond();
        check_val("active after start", 8'h01, {7'h00, active});
        for (int i = 7; i >= 0; i--) begin
            i_master.bit_xfer(a[i], s);
        end
        check_val("active before ninth", 8'h01, {7'h00, active});
        i_master.bit_xfer(1'b1, s);
        check_val("mismatch ack", 8'h01, {7'h00, s});
        check_val("active after ninth", 8'h00, {7'h00, active});
        i_master.stop_cond();
    endtask : sc_mismatch

    task automatic sc_read;
        logic [7:0] rx;
        logic ack;
        int n;
        i_master.start_cond();
        i_master.byte_xfer({DEV, 1'b1}, 1'b1, rx, ack);
        check_val("read addr ack", 8'h00, {7'h00, ack});
        i_master.byte_xfer(8'hFF, 1'b1, rx, ack);
        check_val("read data", RD_BYTE, rx);
        check_range("read requests", 1, 1, rd_pulses);
        i_master.stop_cond();
        wait_active(1'b0, 80, n);
        check_range("standby after read stop", 51, 56, n);
    endtask : sc_read

    task automatic sc_restart;
        logic [7:0] rx;
        logic ack;
        int n;
        i_master.start_cond();
        i_master.byte_xfer({DEV, 1'b0}, 1'b1, rx, ack);
        check_val("restart write addr ack", 8'h00, {7'h00, ack});
        i_master.byte_xfer(8'h3A, 1'b1, rx, ack);
        check_val("restart wr_data", 8'h3A, last_wr);
        i_master.start_cond();
        i_master.byte_xfer({DEV, 1'b1}, 1'b1, rx, ack);
        check_val("restart read addr ack", 8'h00, {7'h00, ack});
        i_master.byte_xfer(8'hFF, 1'b1, rx, ack);
        check_val("restart read data", RD_BYTE, rx);
        check_range("restart read requests", 2, 2, rd_pulses);
        i_master.stop_cond();
        wait_active(1'b0, 80, n);
        check_range("standby after restart read", 51, 56, n);
        check_range("no write after restart", 0, 0, busy_cyc);
    endtask : sc_restart

    task automatic sc_write;
        logic [7:0] rx;
        logic ack;
        int tries;
        int n;
        i_master.start_cond();
        i_master.byte_xfer({DEV, 1'b0}, 1'b1, rx, ack);
        check_val("write addr ack", 8'h00, {7'h00, ack});
        i_master.byte_xfer(8'h5C, 1'b1, rx, ack);
        check_val("data ack", 8'h00, {7'h00, ack});
        check_val("wr_data", 8'h5C, last_wr);
        i_master.stop_cond();
        repeat (8) @(posedge core_clk);
        #1;
        check_val("write_busy", 8'h01, {7'h00, write_busy});
        i_master.poll_ack({DEV, 1'b0}, 20, tries);
        check_range("polls until ack", 2, 19, tries);
        check_range("sda pulled while busy", 0, 0, oe_busy);
        check_range("idle while busy", 0, 0, busy_idle);
        // Launch flop and done-to-state step add two cycles
        check_range("write cycles", WC + 2, WC + 2, busy_cyc);
        wait_active(1'b0, 80, n);
        check_range("standby after poll", 51, 56, n);
    endtask : sc_write

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        // Scaled settling time so the run stays short
        repeat (PU_WRITE_CYC) @(posedge core_clk);
        sc_mismatch();
        sc_read();
        sc_restart();
        sc_write();
        tally_and_finish();
    end
endmodule : tb_eew_core
